/* File: design/acl_pkg.sv */
package acl_pkg;

  localparam int          PORT_W     = 3;
  localparam int          ADDR_W     = 12;
  localparam logic [15:0] TL_IP6     = 16'h86DD;
  localparam logic [15:0] TL_IP4     = 16'h0800;
  localparam logic [15:0] TL_ARP     = 16'h0806;
  localparam logic [15:0] TL_RARP    = 16'h8035;
  localparam logic [15:0] TL_OAM     = 16'h8902;
  localparam logic [15:0] TL_LEN_MAX = 16'h0600;
  localparam logic [15:0] TL_PTP     = 16'h88F7;
  localparam logic [15:0] PTP_PORT_A = 16'h013F;
  localparam logic [15:0] PTP_PORT_B = 16'h0140;
  localparam logic [3:0]  VER6       = 4'h6;
  localparam logic [3:0]  VER4       = 4'h4;
  localparam logic [7:0]  V6_MC_TOP  = 8'hFF;
  localparam logic [3:0]  V4_MC_TOP  = 4'hE;
  localparam logic [7:0]  PR_TCP     = 8'h06;
  localparam logic [7:0]  PR_UDP     = 8'h11;
  localparam logic [7:0]  SAP_SNAP   = 8'hAA;
  localparam logic [7:0]  CTL_SNAP   = 8'h03;
  localparam logic [1:0]  POS_LINK   = 2'h0;

  // Register map and per-lookup setting layout
  localparam logic [11:0] CFG_BASE   = 12'h000;
  localparam logic [11:0] STAT_ADDR  = 12'h100;
  localparam logic [15:0] CFG_RST    = 16'h0000;
  localparam int          LK_W       = 8;
  localparam int          LK_EN      = 0;
  localparam int          LK_ARP     = 1;
  localparam int          LK_V6      = 2;
  localparam int          LK_V6MC    = 3;
  localparam int          LK_V4      = 4;
  localparam int          LK_V4MC    = 6;
  localparam logic [1:0]  V4_SEVEN   = 2'h0;
  localparam logic [1:0]  V4_TP      = 2'h1;
  localparam logic [1:0]  V4_NTP     = 2'h2;
  localparam int          ST_FT      = 0;
  localparam int          ST_K0      = 4;
  localparam int          ST_K1      = 8;
  localparam int          ST_PTP     = 12;
  localparam int          ST_CW      = 13;
  localparam int          ST_CNT     = 16;

  typedef enum logic [3:0] {
    FT_IP6_MC, FT_IP6_UC, FT_IP4_MC, FT_IP4_UC, FT_ARP,
    FT_OAM, FT_SNAP, FT_LLC, FT_ETYPE, FT_NONE
  } acl_ftype_e;

  typedef enum logic [3:0] {
    KEY_NONE, KEY_V6_VLAN, KEY_V4_VLAN, KEY_SEVEN, KEY_V4_TP,
    KEY_V4_NTP, KEY_LINK, KEY_ARP, KEY_CUSTOM
  } acl_key_e;

  typedef enum logic [1:0] {L4_TCP, L4_UDP, L4_OTHER} acl_l4_e;

  typedef struct packed {
    logic              popped_cw;
    logic [PORT_W-1:0] port;
    logic [15:0]       type_len;
    logic [3:0]        ip_nibble;
    logic [7:0]        ip6_dst_top;
    logic [3:0]        ip4_dst_top;
    logic [7:0]        proto;
    logic [15:0]       udp_dport;
    logic [7:0]        dsap;
    logic [7:0]        ssap;
    logic [7:0]        ctrl;
    logic [47:0]       dmac;
    logic [47:0]       smac;
    logic [63:0]       eth_pl;
    logic [63:0]       udp_pl;
    logic              cust_req;
    logic [1:0]        cust_pos;
  } acl_frame_s;

  typedef struct packed {
    logic [PORT_W-1:0] port;
    acl_ftype_e        ftype;
    acl_l4_e           l4;
    logic              ptp;
    logic [63:0]       ptp_bytes;
    logic [47:0]       dmac;
    logic [47:0]       smac;
    acl_key_e          key0;
    acl_key_e          key1;
    logic [1:0]        cust_pos;
  } acl_result_s;

endpackage : acl_pkg

/* File: design/acl_frame_type_key_select.sv */
`timescale 1ns/1ps
module acl_frame_type_key_select #(
  parameter int NPORTS = 8
) (
  // Clock, reset, enable
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                ce,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Parsed frame in
  input  wire logic                frm_valid,
  input  wire acl_pkg::acl_frame_s frm,
  // Classification out
  output logic                     res_valid,
  output acl_pkg::acl_result_s     res
);

  localparam int PI_W = (NPORTS > 1) ? $clog2(NPORTS) : 1;

  logic [15:0]          cfg_q [NPORTS];
  logic [31:0]          prdata_q;
  logic                 pslverr_q;
  logic                 rd_ok_q;
  logic                 res_valid_q;
  acl_pkg::acl_result_s res_q;
  logic                 cw_q;
  logic [15:0]          cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB access

  logic [5:0]  pidx;
  logic        cfg_hit;
  logic        st_hit;
  logic        wr_en;
  logic [31:0] rd_data;

  assign pidx = paddr[7:2];

  always_comb begin
    cfg_hit = 1'b0;
    st_hit  = 1'b0;
    if (paddr[1:0] == 2'h0 && paddr[11:8] == acl_pkg::CFG_BASE[11:8]
        && int'(pidx) < NPORTS) begin
      cfg_hit = 1'b1;
    end else if (paddr == acl_pkg::STAT_ADDR) begin
      st_hit = 1'b1;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    if (cfg_hit) begin
      rd_data = {16'h0000, cfg_q[pidx[PI_W-1:0]]};
    end else if (st_hit) begin
      rd_data[acl_pkg::ST_FT +: 4]   = res_q.ftype;
      rd_data[acl_pkg::ST_K0 +: 4]   = res_q.key0;
      rd_data[acl_pkg::ST_K1 +: 4]   = res_q.key1;
      rd_data[acl_pkg::ST_PTP]       = res_q.ptp;
      rd_data[acl_pkg::ST_CW]        = cw_q;
      rd_data[acl_pkg::ST_CNT +: 16] = cnt_q;
    end
  end

  // Read data is snapshotted one cycle ahead so prdata comes from a flop
  assign pready  = psel & penable & ce & rd_ok_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & pready;
  assign wr_en   = pready & pwrite & ~pslverr_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      rd_ok_q   <= 1'b0;
    end else if (ce) begin
      prdata_q  <= rd_data;
      pslverr_q <= ~(cfg_hit | st_hit);
      rd_ok_q   <= psel & ~pready;
    end
  end

  generate
    for (genvar p = 0; p < NPORTS; p++) begin : g_cfg
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          cfg_q[p] <= acl_pkg::CFG_RST;
        end else if (ce && wr_en && cfg_hit && pidx == 6'(p)) begin
          cfg_q[p] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Frame type

  acl_pkg::acl_ftype_e ft;
  acl_pkg::acl_l4_e    l4;
  logic                is_ip;
  logic                is_v6;
  logic                is_v4;
  logic                ptp;
  logic [63:0]         ptp_bytes;

  always_comb begin
    is_v6 = 1'b0;
    is_v4 = 1'b0;
    if (frm.popped_cw) begin
      is_v6 = frm.ip_nibble == acl_pkg::VER6;
      is_v4 = frm.ip_nibble == acl_pkg::VER4;
    end else begin
      is_v6 = frm.type_len == acl_pkg::TL_IP6 && frm.ip_nibble == acl_pkg::VER6;
      is_v4 = frm.type_len == acl_pkg::TL_IP4 && frm.ip_nibble == acl_pkg::VER4;
    end
  end

  always_comb begin
    ft = acl_pkg::FT_NONE;
    if (is_v6) begin
      ft = (frm.ip6_dst_top == acl_pkg::V6_MC_TOP) ? acl_pkg::FT_IP6_MC
                                                   : acl_pkg::FT_IP6_UC;
    end else if (is_v4) begin
      ft = (frm.ip4_dst_top == acl_pkg::V4_MC_TOP) ? acl_pkg::FT_IP4_MC
                                                   : acl_pkg::FT_IP4_UC;
    end else if (frm.popped_cw) begin
      ft = acl_pkg::FT_NONE;
    end else if (frm.type_len == acl_pkg::TL_ARP || frm.type_len == acl_pkg::TL_RARP) begin
      ft = acl_pkg::FT_ARP;
    end else if (frm.type_len == acl_pkg::TL_OAM) begin
      ft = acl_pkg::FT_OAM;
    end else if (frm.type_len < acl_pkg::TL_LEN_MAX) begin
      if (frm.dsap == acl_pkg::SAP_SNAP && frm.ssap == acl_pkg::SAP_SNAP
          && frm.ctrl == acl_pkg::CTL_SNAP) begin
        ft = acl_pkg::FT_SNAP;
      end else begin
        ft = acl_pkg::FT_LLC;
      end
    end else begin
      ft = acl_pkg::FT_ETYPE;
    end
  end

  assign is_ip = is_v6 | is_v4;

  always_comb begin
    l4 = acl_pkg::L4_OTHER;
    if (is_ip && frm.proto == acl_pkg::PR_TCP) begin
      l4 = acl_pkg::L4_TCP;
    end else if (is_ip && frm.proto == acl_pkg::PR_UDP) begin
      l4 = acl_pkg::L4_UDP;
    end
  end

  always_comb begin
    ptp       = 1'b0;
    ptp_bytes = 64'h0;
    if (ft == acl_pkg::FT_ETYPE && frm.type_len == acl_pkg::TL_PTP) begin
      ptp       = 1'b1;
      ptp_bytes = frm.eth_pl;
    end else if (l4 == acl_pkg::L4_UDP && (frm.udp_dport == acl_pkg::PTP_PORT_A
                 || frm.udp_dport == acl_pkg::PTP_PORT_B)) begin
      ptp       = 1'b1;
      ptp_bytes = frm.udp_pl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key choice

  function automatic acl_pkg::acl_key_e pick_key(
    input acl_pkg::acl_ftype_e ftype,
    input logic [7:0]          s,
    input logic                cust,
    input logic [1:0]          pos,
    input logic                cw
  );
    pick_key = acl_pkg::KEY_NONE;
    if (!s[acl_pkg::LK_EN]) begin
      pick_key = acl_pkg::KEY_NONE;
    end else if (cust) begin
      pick_key = (cw && pos == acl_pkg::POS_LINK) ? acl_pkg::KEY_NONE : acl_pkg::KEY_CUSTOM;
    end else begin
      case (ftype)
        acl_pkg::FT_IP6_MC: begin
          pick_key = s[acl_pkg::LK_V6]   ? acl_pkg::KEY_LINK    :
                     s[acl_pkg::LK_V6MC] ? acl_pkg::KEY_V6_VLAN : acl_pkg::KEY_SEVEN;
        end
        acl_pkg::FT_IP6_UC: begin
          pick_key = s[acl_pkg::LK_V6] ? acl_pkg::KEY_LINK : acl_pkg::KEY_SEVEN;
        end
        acl_pkg::FT_IP4_MC, acl_pkg::FT_IP4_UC: begin
          if (ftype == acl_pkg::FT_IP4_MC && s[acl_pkg::LK_V4MC]) begin
            pick_key = acl_pkg::KEY_V4_VLAN;
          end else if (s[acl_pkg::LK_V4 +: 2] == acl_pkg::V4_SEVEN) begin
            pick_key = acl_pkg::KEY_SEVEN;
          end else if (s[acl_pkg::LK_V4 +: 2] == acl_pkg::V4_TP) begin
            pick_key = acl_pkg::KEY_V4_TP;
          end else if (s[acl_pkg::LK_V4 +: 2] == acl_pkg::V4_NTP) begin
            pick_key = acl_pkg::KEY_V4_NTP;
          end else begin
            pick_key = acl_pkg::KEY_LINK;
          end
        end
        acl_pkg::FT_ARP: begin
          pick_key = s[acl_pkg::LK_ARP] ? acl_pkg::KEY_LINK : acl_pkg::KEY_ARP;
        end
        acl_pkg::FT_NONE: begin
          pick_key = acl_pkg::KEY_NONE;
        end
        default: begin
          pick_key = acl_pkg::KEY_LINK;
        end
      endcase
    end
  endfunction : pick_key

  logic        port_ok;
  logic [15:0] pcfg;

  // Out-of-range port numbers see an all-disabled setting
  assign port_ok = int'(frm.port) < NPORTS;
  assign pcfg    = port_ok ? cfg_q[frm.port[PI_W-1:0]] : acl_pkg::CFG_RST;

  ////////////////////////////////////////////////////////////////////////////
  // Result stage

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      res_valid_q <= 1'b0;
    end else if (ce) begin
      res_valid_q <= frm_valid;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      res_q <= '0;
      cw_q  <= 1'b0;
    end else if (ce && frm_valid) begin
      res_q.port      <= frm.port;
      res_q.ftype     <= ft;
      res_q.l4        <= l4;
      res_q.ptp       <= ptp;
      res_q.ptp_bytes <= ptp_bytes;
      // No link layer exists once labels are popped
      res_q.dmac      <= frm.popped_cw ? 48'h0 : frm.dmac;
      res_q.smac      <= frm.popped_cw ? 48'h0 : frm.smac;
      res_q.key0      <= pick_key(ft, pcfg[0 +: acl_pkg::LK_W], frm.cust_req,
                                  frm.cust_pos, frm.popped_cw);
      res_q.key1      <= pick_key(ft, pcfg[acl_pkg::LK_W +: acl_pkg::LK_W], frm.cust_req,
                                  frm.cust_pos, frm.popped_cw);
      res_q.cust_pos  <= frm.cust_pos;
      cw_q            <= frm.popped_cw;
    end
  end

  // Frame counter wraps; software diffs two reads
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 16'h0000;
    end else if (ce && frm_valid) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign res_valid = res_valid_q;
  assign res       = res_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic in_eth;
  assign in_eth = frm_valid & ce & ~frm.popped_cw;

  property p_ip6;
    in_eth && frm.type_len == acl_pkg::TL_IP6 && frm.ip_nibble == acl_pkg::VER6
      && frm.ip6_dst_top == acl_pkg::V6_MC_TOP |=> res.ftype == acl_pkg::FT_IP6_MC;
  endproperty
  a_ip6: assert property (p_ip6) else $error("IPv6 multicast misclassified");

  property p_l4;
    frm_valid && ce && is_ip && frm.proto == acl_pkg::PR_UDP |=> res.l4 == acl_pkg::L4_UDP;
  endproperty
  a_l4: assert property (p_l4) else $error("UDP not marked");

  property p_ip4;
    in_eth && frm.type_len == acl_pkg::TL_IP4 && frm.ip_nibble == acl_pkg::VER4
      && frm.ip4_dst_top != acl_pkg::V4_MC_TOP |=> res.ftype == acl_pkg::FT_IP4_UC;
  endproperty
  a_ip4: assert property (p_ip4) else $error("IPv4 unicast misclassified");

  property p_arp;
    in_eth && frm.type_len == acl_pkg::TL_RARP |=> res.ftype == acl_pkg::FT_ARP;
  endproperty
  a_arp: assert property (p_arp) else $error("RARP misclassified");

  property p_llc;
    in_eth && frm.type_len < acl_pkg::TL_LEN_MAX && frm.dsap != acl_pkg::SAP_SNAP
      |=> res.ftype == acl_pkg::FT_LLC;
  endproperty
  a_llc: assert property (p_llc) else $error("LLC misclassified");

  property p_ptp;
    in_eth && frm.type_len == acl_pkg::TL_PTP
      |=> res.ptp && res.ptp_bytes == $past(frm.eth_pl);
  endproperty
  a_ptp: assert property (p_ptp) else $error("Timing frame over Ethernet missed");

  property p_dis;
    frm_valid && ce && !pcfg[acl_pkg::LK_EN] |=> res.key0 == acl_pkg::KEY_NONE;
  endproperty
  a_dis: assert property (p_dis) else $error("Disabled lookup made a key");

  property p_link;
    res_valid && res.key1 != acl_pkg::KEY_NONE && res.key1 != acl_pkg::KEY_CUSTOM
      && res.ftype inside {acl_pkg::FT_OAM, acl_pkg::FT_SNAP, acl_pkg::FT_LLC,
      acl_pkg::FT_ETYPE} |-> res.key1 == acl_pkg::KEY_LINK;
  endproperty
  a_link: assert property (p_link) else $error("Fixed key not link-layer");

  property p_cwzero;
    frm_valid && ce && frm.popped_cw |=> res.dmac == 48'h0 && res.smac == 48'h0 && cw_q;
  endproperty
  a_cwzero: assert property (p_cwzero) else $error("Popped frame kept MAC");

  property p_cwnone;
    frm_valid && ce && frm.popped_cw && !frm.cust_req && frm.ip_nibble != acl_pkg::VER4
      && frm.ip_nibble != acl_pkg::VER6
      |=> res.key0 == acl_pkg::KEY_NONE && res.key1 == acl_pkg::KEY_NONE;
  endproperty
  a_cwnone: assert property (p_cwnone) else $error("Key for non-IP popped frame");

  property p_tcp;
    frm_valid && ce && is_ip && frm.proto == acl_pkg::PR_TCP |=> res.l4 == acl_pkg::L4_TCP;
  endproperty
  a_tcp: assert property (p_tcp) else $error("TCP not marked");

  property p_oam;
    in_eth && frm.type_len == acl_pkg::TL_OAM |=> res.ftype == acl_pkg::FT_OAM;
  endproperty
  a_oam: assert property (p_oam) else $error("Maintenance frame misclassified");

  property p_snap;
    in_eth && frm.type_len < acl_pkg::TL_LEN_MAX && frm.dsap == acl_pkg::SAP_SNAP
      && frm.ssap == acl_pkg::SAP_SNAP && frm.ctrl == acl_pkg::CTL_SNAP
      |=> res.ftype == acl_pkg::FT_SNAP;
  endproperty
  a_snap: assert property (p_snap) else $error("SNAP misclassified");

  property p_ptpudp;
    frm_valid && ce && is_ip && frm.proto == acl_pkg::PR_UDP
      && frm.udp_dport == acl_pkg::PTP_PORT_B
      |=> res.ptp && res.ptp_bytes == $past(frm.udp_pl);
  endproperty
  a_ptpudp: assert property (p_ptpudp) else $error("Timing frame over UDP missed");

  // A VLAN key on unicast traffic would hit rules written for group traffic
  property p_v4vlan;
    res_valid && res.ftype == acl_pkg::FT_IP4_UC
      |-> res.key0 != acl_pkg::KEY_V4_VLAN && res.key1 != acl_pkg::KEY_V4_VLAN;
  endproperty
  a_v4vlan: assert property (p_v4vlan) else $error("VLAN key on unicast frame");

  property p_cwpos;
    frm_valid && ce && frm.popped_cw && frm.cust_req && frm.cust_pos == acl_pkg::POS_LINK
      |=> res.key0 == acl_pkg::KEY_NONE && res.key1 == acl_pkg::KEY_NONE;
  endproperty
  a_cwpos: assert property (p_cwpos) else $error("Link position used after pop");

  c_ptp_udp: cover property (res_valid && res.ptp && res.l4 == acl_pkg::L4_UDP);
  c_custom:  cover property (res_valid && res.key0 == acl_pkg::KEY_CUSTOM);
  c_vlan:    cover property (res_valid && res.key1 == acl_pkg::KEY_V4_VLAN);
  c_apbwr:   cover property (wr_en && cfg_hit);
  c_popped:  cover property (res_valid && cw_q && res.ftype == acl_pkg::FT_IP6_UC);

endmodule : acl_frame_type_key_select

/* File: test/acl_lookup_sink.sv */
`timescale 1ns/1ps
module acl_lookup_sink (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 arst_n,
  // Classification from the selector
  input wire logic                 res_valid,
  input wire acl_pkg::acl_result_s res
);
  // Lookup engine stand-in: accepts every result, counts pulses and keeps the last first key
  int                 seen_q;
  acl_pkg::acl_key_e  last_k0_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_q    <= 0;
      last_k0_q <= acl_pkg::KEY_NONE;
    end else if (res_valid) begin
      seen_q    <= seen_q + 1;
      last_k0_q <= res.key0;
    end
  end
endmodule : acl_lookup_sink

/* File: test/acl_frame_type_key_select_test.sv */
`timescale 1ns/1ps
module acl_frame_type_key_select_test;
  localparam int NP = 6;
  logic                 clk = 1'b0;
  logic                 arst_n = 1'b0;
  logic                 ce = 1'b1;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 frm_valid = 1'b0;
  acl_pkg::acl_frame_s  frm = '0;
  logic                 res_valid;
  acl_pkg::acl_result_s res;
  logic [15:0]          cfg [8] = '{default: 16'h0};
  int                   err_count = 0;
  int                   num_checks = 0;
  int                   nfrm = 0;

  always #5 clk = ~clk;

  acl_frame_type_key_select #(.NPORTS(NP)) dut_u (
    .clk(clk), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frm_valid(frm_valid), .frm(frm),
    .res_valid(res_valid), .res(res));

  acl_lookup_sink sink_u (.clk(clk), .arst_n(arst_n), .res_valid(res_valid), .res(res));

  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Access ends at the rising edge where pready is seen high; data taken there
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    chk(n == 1, "wait states");
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  ////////////////////////////////////////////////////////////////////////////////
  function automatic acl_pkg::acl_ftype_e rft(acl_pkg::acl_frame_s f);
    logic v6;
    logic v4;
    v6 = (f.popped_cw || f.type_len == 16'h86DD) && f.ip_nibble == 4'h6;
    v4 = (f.popped_cw || f.type_len == 16'h0800) && f.ip_nibble == 4'h4;
    if (v6) return (f.ip6_dst_top == 8'hFF) ? acl_pkg::FT_IP6_MC : acl_pkg::FT_IP6_UC;
    if (v4) return (f.ip4_dst_top == 4'hE) ? acl_pkg::FT_IP4_MC : acl_pkg::FT_IP4_UC;
    if (f.popped_cw) return acl_pkg::FT_NONE;
    if (f.type_len == 16'h0806 || f.type_len == 16'h8035) return acl_pkg::FT_ARP;
    if (f.type_len == 16'h8902) return acl_pkg::FT_OAM;
    if (f.type_len < 16'h0600)
      return (f.dsap == 8'hAA && f.ssap == 8'hAA && f.ctrl == 8'h03) ?
             acl_pkg::FT_SNAP : acl_pkg::FT_LLC;
    return acl_pkg::FT_ETYPE;
  endfunction : rft

  function automatic acl_pkg::acl_key_e rkey(acl_pkg::acl_ftype_e ft, logic [7:0] s,
                                             acl_pkg::acl_frame_s f);
    if (!s[0] || f.port >= NP) return acl_pkg::KEY_NONE;
    if (f.cust_req)
      return (f.popped_cw && f.cust_pos == 2'h0) ? acl_pkg::KEY_NONE : acl_pkg::KEY_CUSTOM;
    case (ft)
      acl_pkg::FT_IP6_MC: return s[2] ? acl_pkg::KEY_LINK :
                                 (s[3] ? acl_pkg::KEY_V6_VLAN : acl_pkg::KEY_SEVEN);
      acl_pkg::FT_IP6_UC: return s[2] ? acl_pkg::KEY_LINK : acl_pkg::KEY_SEVEN;
      acl_pkg::FT_IP4_MC, acl_pkg::FT_IP4_UC: begin
        if (s[6] && ft == acl_pkg::FT_IP4_MC) return acl_pkg::KEY_V4_VLAN;
        return (s[5:4] == 2'h0) ? acl_pkg::KEY_SEVEN : (s[5:4] == 2'h1) ? acl_pkg::KEY_V4_TP :
               (s[5:4] == 2'h2) ? acl_pkg::KEY_V4_NTP : acl_pkg::KEY_LINK;
      end
      acl_pkg::FT_ARP: return s[1] ? acl_pkg::KEY_LINK : acl_pkg::KEY_ARP;
      acl_pkg::FT_NONE: return acl_pkg::KEY_NONE;
      default: return acl_pkg::KEY_LINK;
    endcase
  endfunction : rkey

  task send(input acl_pkg::acl_frame_s f);
    acl_pkg::acl_ftype_e ft;
    acl_pkg::acl_l4_e    l4;
    logic                ip;
    logic                pp;
    ft = rft(f);
    ip = ft <= acl_pkg::FT_IP4_UC;
    l4 = !ip ? acl_pkg::L4_OTHER : (f.proto == 8'h06) ? acl_pkg::L4_TCP :
         (f.proto == 8'h11) ? acl_pkg::L4_UDP : acl_pkg::L4_OTHER;
    pp = (!f.popped_cw && ft == acl_pkg::FT_ETYPE && f.type_len == 16'h88F7) ||
         (l4 == acl_pkg::L4_UDP && (f.udp_dport == 16'd319 || f.udp_dport == 16'd320));
    @(posedge clk);
    frm       <= f;
    frm_valid <= 1'b1;
    @(posedge clk);
    frm_valid <= 1'b0;
    #1;
    nfrm++;
    chk(res_valid === 1'b1, "no result");
    chk(res.ftype === ft, "frame type");
    chk(res.key0 === rkey(ft, cfg[f.port][7:0], f), "first key");
    chk(res.key1 === rkey(ft, cfg[f.port][15:8], f), "second key");
    chk(res.l4 === l4, "transport");
    chk(res.ptp === pp, "timing flag");
    chk(res.ptp_bytes === (!pp ? 64'h0 : ip ? f.udp_pl : f.eth_pl), "timing bytes");
    chk(res.dmac === (f.popped_cw ? 48'h0 : f.dmac), "link fields");
    chk(res.smac === (f.popped_cw ? 48'h0 : f.smac), "source link field");
    chk(res.port === f.port && res.cust_pos === f.cust_pos, "pass-through");
  endtask : send

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #500us;
    err_count++;
    $display("BAD %0t timeout", $time);
    close_out();
  end

  initial begin
    acl_pkg::acl_frame_s f;
    logic [31:0]         r;
    logic                e;
    logic [15:0]         w;
    int                  p;
    logic [15:0]         tl [9];
    logic [319:0]        raw;
    tl = '{16'h86DD, 16'h0800, 16'h0806, 16'h8035, 16'h8902, 16'h88F7,
           16'h05FF, 16'h0600, 16'h1234};
    void'($urandom(12));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < NP; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0, r, e);
      chk(r === 32'h0 && e === 1'b0, "setting reset");
    end
    apb(1'b0, 12'h200, 32'h0, r, e);
    chk(e === 1'b1 && r === 32'h0, "unmapped read");
    apb(1'b1, 12'h100, 32'hFFFFFFFF, r, e);
    apb(1'b0, 12'h100, 32'h0, r, e);
    chk(r === 32'h0 && e === 1'b0, "status write");
    $display("register test done");
    for (int i = 0; i < 300; i++) begin
      p = $urandom % 8;
      if (p < NP && ($urandom % 3 == 0 || i < 8)) begin
        w = 16'($urandom);
        apb(1'b1, 12'(p * 4), {16'($urandom), w}, r, e);
        cfg[p] = w;
        apb(1'b0, 12'(p * 4), 32'h0, r, e);
        chk(r === {16'h0, w} && e === 1'b0, "setting readback");
      end
      for (int k = 0; k < 10; k++)
        raw[k * 32 +: 32] = $urandom;
      f = raw[$bits(acl_pkg::acl_frame_s)-1:0];
      f.port        = 3'(p);
      f.type_len    = tl[$urandom % 9];
      f.ip_nibble   = ($urandom % 2) ? 4'h6 : (($urandom % 2) ? 4'h4 : f.ip_nibble);
      f.popped_cw   = ($urandom % 6 == 0);
      f.cust_req    = ($urandom % 6 == 0);
      f.ip6_dst_top = ($urandom % 2) ? 8'hFF : f.ip6_dst_top;
      f.ip4_dst_top = ($urandom % 2) ? 4'hE : f.ip4_dst_top;
      f.proto       = ($urandom % 2) ? 8'h11 : (($urandom % 2) ? 8'h06 : f.proto);
      f.udp_dport   = ($urandom % 2) ? 16'd319 + 16'($urandom % 2) : f.udp_dport;
      if ($urandom % 2) begin
        f.dsap = 8'hAA;
        f.ssap = 8'hAA;
        f.ctrl = ($urandom % 2) ? 8'h03 : f.ctrl;
      end
      send(f);
      // A frame offered while ce is low must not be taken
      if (i % 50 == 25) begin
        @(posedge clk);
        ce        <= 1'b0;
        frm_valid <= 1'b1;
        @(posedge clk);
        frm_valid <= 1'b0;
        ce        <= 1'b1;
        #1;
        chk(res_valid === 1'b0, "frozen frame taken");
      end
      if (i % 40 == 0) begin
        apb(1'b0, 12'h100, 32'h0, r, e);
        chk(r[3:0] === 4'(rft(f)) && r[31:16] === 16'(nfrm), "status");
      end
    end
    @(posedge clk);
    #1;
    chk(sink_u.seen_q === nfrm, "result count");
    chk(sink_u.last_k0_q === res.key0, "sink key");
    $display("frame test done");
    close_out();
  end
endmodule : acl_frame_type_key_select_test
